// ---- hdl/irt_consts.svh ----
// Purpose: Offsets, field positions, reset values and counts of the IR transmitter.
// Assumes: One 32-bit register word per aligned byte address.
// Notes: Included by the top module and by the bench.
//
// What this block does
// - Timer clock is the reference clock divided by two to the prescale exponent.
// - Carrier stays low until the rise count of timer ticks has elapsed.
// - Carrier falls at the period count, then the cycle repeats.
// - Each encoded bit lasts a programmed number of whole carrier periods.
// - A configuration bit inverts the output polarity.
// - Completion interrupt is raised only while it is enabled.
// - Buffer start address given; buffer is 32-bit words, at most 128.
// - Length of 1 to 4096 bits; exactly that many are sent.
// - Words go out MSB first; a short last word uses upper bits.
// - Start fetches bits by DMA and runs without processor help.
// - A readable busy bit is true only during a transmission.
// - A dedicated bit in the interrupt source bitmap marks completion.
// - The waveform appears on the infra-red timer channel output.
// - Modulated output is carrier AND current bit, before inversion.
`ifndef IRT_CONSTS_SVH
`define IRT_CONSTS_SVH
`define IRT_REF_CLK_HZ 20000000
`define IRT_OFS_CTRL 8'h00
`define IRT_OFS_PRESC 8'h04
`define IRT_OFS_RISE 8'h08
`define IRT_OFS_PERIOD 8'h0C
`define IRT_OFS_BITPER 8'h10
`define IRT_OFS_ADDR 8'h14
`define IRT_OFS_LEN 8'h18
`define IRT_OFS_STATUS 8'h1C
`define IRT_OFS_IRQ_STAT 8'h20
`define IRT_OFS_IRQ_EN 8'h24
`define IRT_OFS_IRQ_CLR 8'h28
`define IRT_CTRL_ENABLE 0
`define IRT_CTRL_INVERT 1
`define IRT_CTRL_START 2
`define IRT_IRQ_DONE 0
`define IRT_MAX_BITS 13'h1000
`define IRT_WORD_BITS 6'h20
`define IRT_WORD_BYTES 32'h00000004
`define IRT_RST_PRESC 4'h0
`define IRT_RST_COUNT 16'h0000
`define IRT_RST_WORD 32'h00000000
`endif

// ---- hdl/irt_pkg.sv ----
// Purpose: Types shared by the IR transmitter files.
// Assumes: Constants come from irt_consts.svh.
// Notes: The state codes change one bit from IDLE to FETCH and from FETCH to RUN; RUN back to IDLE changes both bits.
`default_nettype none
package irt_pkg;
  typedef enum logic [1:0] {
    IRT_IDLE = 2'h0,
    IRT_FETCH = 2'h1,
    IRT_RUN = 2'h3
  } irt_state_t;
  typedef logic [7:0] irt_addr_t;
endpackage
`default_nettype wire

// ---- hdl/irt_top.sv ----
// Purpose: On-off-keyed infra-red waveform generator with DMA bit fetch.
// Assumes: DMA read data arrive with dma_ack; latency below one bit period.
// Notes: Registers on a plain strobe port; read data one cycle later.
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "irt_consts.svh"
module irt_top (
  input wire logic ref_clk, // 20 MHz clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire irt_pkg::irt_addr_t reg_addr, // Register byte address.
  input wire logic [31:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [31:0] reg_rdata, // Read data, cycle after the strobe.
  output logic dma_req, // DMA word read request.
  output logic [31:0] dma_addr, // DMA byte address.
  input wire logic dma_ack, // DMA word delivered.
  input wire logic [31:0] dma_rdata, // DMA data, valid with ack.
  output logic ir_waveform_output, // Modulated waveform.
  output logic irq // Level interrupt.
);
  import irt_pkg::*;

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  logic enable;
  logic output_invert;
  logic [3:0] timer_prescale_exponent;
  logic [15:0] carrier_rise_count;
  logic [15:0] carrier_period_count;
  logic [15:0] bit_period_carriers;
  logic [31:0] buf_addr;
  logic [12:0] tx_len;
  logic [0:0] irq_stat;
  logic [0:0] irq_en;
  logic busy;
  irt_state_t state;
  logic [14:0] presc_cnt;
  logic [15:0] tick_cnt;
  logic [15:0] carr_cnt;
  logic carrier;
  logic [31:0] shreg;
  logic [31:0] pref;
  logic pref_v;
  logic [4:0] bit_idx;
  logic [12:0] bits_left;
  logic done_evt;

  logic start_req;
  logic clr_done;
  logic [14:0] presc_mask;
  logic tick;
  logic period_end;
  logic bit_end;
  logic last_bit;
  logic word_end;
  logic [12:0] word_rem;
  logic need_more;
  logic ir_irq_source;
  logic mod_bit;

  // Start is honoured only when enabled, idle and given a legal length.
  assign start_req = reg_wr && (reg_addr == `IRT_OFS_CTRL) && reg_wdata[`IRT_CTRL_START] &&
    reg_wdata[`IRT_CTRL_ENABLE] && (state == IRT_IDLE) && (tx_len != 13'h0000) &&
    (tx_len <= `IRT_MAX_BITS);
  assign clr_done = reg_wr && (reg_addr == `IRT_OFS_IRQ_CLR) && reg_wdata[`IRT_IRQ_DONE];

  // Timer tick once every two-to-the-exponent reference cycles.
  assign presc_mask = 15'((16'h0001 << timer_prescale_exponent) - 16'h0001);
  assign tick = (state == IRT_RUN) && (presc_cnt == presc_mask);
  assign period_end = tick && (tick_cnt == carrier_period_count - 16'h0001);
  assign bit_end = period_end && (carr_cnt == bit_period_carriers - 16'h0001);
  assign last_bit = bit_end && (bits_left == 13'h0001);
  assign word_end = bit_end && (bit_idx == 5'h1F);

  // A prefetch is needed while bits remain beyond the current word.
  assign word_rem = 13'(`IRT_WORD_BITS - {1'b0, bit_idx});
  assign need_more = bits_left > word_rem;
  assign ir_irq_source = irq_stat[`IRT_IRQ_DONE];

  // Gating of the carrier by the current encoded bit.
  assign mod_bit = carrier & shreg[31];

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // Configuration written by software; clearing enable aborts a frame.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      enable <= 1'b0;
      output_invert <= 1'b0;
      timer_prescale_exponent <= `IRT_RST_PRESC;
      carrier_rise_count <= `IRT_RST_COUNT;
      carrier_period_count <= `IRT_RST_COUNT;
      bit_period_carriers <= `IRT_RST_COUNT;
      buf_addr <= `IRT_RST_WORD;
      tx_len <= 13'h0000;
      irq_en <= 1'b0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `IRT_OFS_CTRL: begin
          enable <= reg_wdata[`IRT_CTRL_ENABLE];
          output_invert <= reg_wdata[`IRT_CTRL_INVERT];
        end
        `IRT_OFS_PRESC: timer_prescale_exponent <= reg_wdata[3:0];
        `IRT_OFS_RISE: carrier_rise_count <= reg_wdata[15:0];
        `IRT_OFS_PERIOD: carrier_period_count <= reg_wdata[15:0];
        `IRT_OFS_BITPER: bit_period_carriers <= reg_wdata[15:0];
        `IRT_OFS_ADDR: buf_addr <= {reg_wdata[31:2], 2'b00};
        `IRT_OFS_LEN: tx_len <= reg_wdata[12:0];
        `IRT_OFS_IRQ_EN: irq_en <= reg_wdata[0:0];
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  // Unmapped and write-only offsets read as zero.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `IRT_RST_WORD;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `IRT_OFS_CTRL: reg_rdata <= {30'h0, output_invert, enable};
        `IRT_OFS_PRESC: reg_rdata <= {28'h0, timer_prescale_exponent};
        `IRT_OFS_RISE: reg_rdata <= {16'h0, carrier_rise_count};
        `IRT_OFS_PERIOD: reg_rdata <= {16'h0, carrier_period_count};
        `IRT_OFS_BITPER: reg_rdata <= {16'h0, bit_period_carriers};
        `IRT_OFS_ADDR: reg_rdata <= buf_addr;
        `IRT_OFS_LEN: reg_rdata <= {19'h0, tx_len};
        `IRT_OFS_STATUS: reg_rdata <= {31'h0, busy};
        `IRT_OFS_IRQ_STAT: reg_rdata <= {31'h0, ir_irq_source};
        `IRT_OFS_IRQ_EN: reg_rdata <= {31'h0, irq_en};
        default: reg_rdata <= `IRT_RST_WORD;
      endcase
    end else begin
      reg_rdata <= `IRT_RST_WORD;
    end
  end

  // ------------------------------------------------------------
  // Timer and carrier
  // ------------------------------------------------------------
  // Prescaler restarts with each frame so the first period is exact.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      presc_cnt <= 15'h0000;
    end else if (state != IRT_RUN || tick) begin
      presc_cnt <= 15'h0000;
    end else begin
      presc_cnt <= presc_cnt + 15'h0001;
    end
  end

  // Carrier is low for the rise count, high up to the period count.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= 16'h0000;
      carr_cnt <= 16'h0000;
      carrier <= 1'b0;
    end else if (state != IRT_RUN) begin
      tick_cnt <= 16'h0000;
      carr_cnt <= 16'h0000;
      carrier <= 1'b0;
    end else if (tick) begin
      if (period_end) begin
        tick_cnt <= 16'h0000;
        carrier <= 1'b0;
        carr_cnt <= bit_end ? 16'h0000 : carr_cnt + 16'h0001;
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
        carrier <= (tick_cnt + 16'h0001) >= carrier_rise_count;
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer and DMA
  // ------------------------------------------------------------
  // The next word is prefetched so word boundaries carry no gap.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= IRT_IDLE;
      dma_req <= 1'b0;
      dma_addr <= `IRT_RST_WORD;
      shreg <= `IRT_RST_WORD;
      pref <= `IRT_RST_WORD;
      pref_v <= 1'b0;
      bit_idx <= 5'h00;
      bits_left <= 13'h0000;
      done_evt <= 1'b0;
    end else begin
      done_evt <= 1'b0;
      if (!enable) begin
        state <= IRT_IDLE;
        dma_req <= 1'b0;
        pref_v <= 1'b0;
      end else begin
        unique case (state)
          IRT_IDLE: begin
            if (start_req) begin
              dma_addr <= buf_addr;
              dma_req <= 1'b1;
              bits_left <= tx_len;
              bit_idx <= 5'h00;
              pref_v <= 1'b0;
              state <= IRT_FETCH;
            end
          end
          IRT_FETCH: begin
            if (dma_ack) begin
              dma_req <= 1'b0;
              shreg <= dma_rdata;
              dma_addr <= dma_addr + `IRT_WORD_BYTES;
              state <= IRT_RUN;
            end
          end
          IRT_RUN: begin
            if (dma_req && dma_ack) begin
              dma_req <= 1'b0;
              pref <= dma_rdata;
              pref_v <= 1'b1;
              dma_addr <= dma_addr + `IRT_WORD_BYTES;
            end else if (!dma_req && !pref_v && need_more && !bit_end) begin
              dma_req <= 1'b1;
            end
            if (last_bit) begin
              state <= IRT_IDLE;
              done_evt <= 1'b1;
              dma_req <= 1'b0;
            end else if (bit_end) begin
              bits_left <= bits_left - 13'h0001;
              bit_idx <= bit_idx + 5'h01;
              if (word_end) begin
                shreg <= pref;
                pref_v <= 1'b0;
              end else begin
                shreg <= {shreg[30:0], 1'b0};
              end
            end
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Output, busy and interrupt
  // ------------------------------------------------------------
  // Outside a frame the pin rests at its inactive level.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ir_waveform_output <= 1'b0;
      busy <= 1'b0;
    end else begin
      ir_waveform_output <= ((state == IRT_RUN) & mod_bit) ^ output_invert;
      // Busy rises with an accepted start, so a read right behind the start already sees it.
      busy <= enable && (((state != IRT_IDLE) && !last_bit) || start_req);
    end
  end

  // Sticky completion bit; a new event wins over a clear.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq_stat <= done_evt ? 1'b1 : (clr_done ? 1'b0 : irq_stat);
      irq <= |(irq_stat & irq_en);
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_last;
    state == IRT_RUN && last_bit && enable;
  endsequence
  sequence s_idle_done;
    state == IRT_IDLE && done_evt && !busy;
  endsequence

  AST_PRESC_TICK: assert property (@(posedge ref_clk) disable iff (!resetn)
    tick |=> presc_cnt == 15'h0000 && $past(presc_cnt) == $past(presc_mask))
    else $error("Prescaler tick at wrong count.");
  AST_CARR_LOW: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state == IRT_RUN && tick_cnt < carrier_rise_count) |-> !carrier)
    else $error("Carrier high before rise count.");
  AST_CARR_WRAP: assert property (@(posedge ref_clk) disable iff (!resetn)
    (period_end && !last_bit) |=> tick_cnt == 16'h0000 && !carrier)
    else $error("Carrier period did not restart.");
  AST_BIT_ADV: assert property (@(posedge ref_clk) disable iff (!resetn)
    (bit_end && !last_bit && enable) |=> bits_left == $past(bits_left) - 13'h0001)
    else $error("Bit did not advance at bit period end.");
  AST_OUT_POL: assert property (@(posedge ref_clk) disable iff (!resetn)
    1'b1 |=> ir_waveform_output == ($past((state == IRT_RUN) & mod_bit) ^ $past(output_invert)))
    else $error("Output polarity wrong.");
  AST_IRQ_GATE: assert property (@(posedge ref_clk) disable iff (!resetn)
    1'b1 |=> irq == |($past(irq_stat) & $past(irq_en)))
    else $error("Interrupt not gated by enable.");
  AST_DMA_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
    (dma_req && !dma_ack && enable && !last_bit) |=> dma_req && $stable(dma_addr))
    else $error("DMA request dropped before ack.");
  AST_BUSY: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state == IRT_FETCH && enable) |=> busy)
    else $error("Busy low during transmission.");
  AST_DONE: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_last |=> s_idle_done ##1 irq_stat[0])
    else $error("Completion sequence wrong.");
endmodule
`default_nettype wire

// ---- tb/irt_far_model.sv ----
// Purpose: RAM behind the DMA port and the LED driver stage of the IR transmitter.
// Assumes: One clock; a held request is answered after lat idle cycles.
// Notes: Read data toggle whenever no word is delivered.
`timescale 1ns/10ps
`default_nettype none
module irt_far_model (
  input wire logic ref_clk, // Clock.
  input wire logic resetn, // Reset, active low.
  input wire logic [3:0] lat, // Answer delay in cycles.
  input wire logic dma_req, // Word request.
  input wire logic [31:0] dma_addr, // Byte address.
  output logic dma_ack, // Word delivered.
  output logic [31:0] dma_rdata, // Word data.
  input wire logic ir_waveform_output, // Pin level.
  input wire logic output_invert, // Driver polarity.
  output logic led_on // LED lit.
);
  logic [31:0] mem [0:255];
  logic [3:0] wait_cnt;
  // One ack per held request; toggling data keeps a stale word from looking right.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dma_ack <= 1'b0;
      dma_rdata <= 32'h00000000;
      wait_cnt <= 4'h0;
    end else if (dma_req && !dma_ack && wait_cnt >= lat) begin
      dma_ack <= 1'b1;
      dma_rdata <= mem[dma_addr[9:2]];
      wait_cnt <= 4'h0;
    end else begin
      dma_ack <= 1'b0;
      dma_rdata <= ~dma_rdata;
      wait_cnt <= (dma_req && !dma_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
  // The transistor conducts at the active level of the pin.
  assign led_on = ir_waveform_output ^ output_invert;
endmodule
`default_nettype wire

// ---- tb/irt_top_test.sv ----
// Purpose: Self-checking bench of the IR transmitter.
// Assumes: Frames start with a one bit so pulse times can be decoded.
// Notes: Bits are decoded from LED pulse times, not from exact cycles.
`timescale 1ns/10ps
`default_nettype none
`include "irt_consts.svh"
module irt_top_test;
  import irt_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  irt_addr_t reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic inv = 1'b0;
  logic watch = 1'b0;
  logic [3:0] lat = 4'h0;
  logic [31:0] reg_rdata, dma_addr, dma_rdata, rv;
  logic dma_req, dma_ack, ir_waveform_output, irq, led_on;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int hi_len = 0;
  int e, r, p, b;
  int rises[$];
  always #25 ref_clk = ~ref_clk;
  irt_top irt_top_i (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_req(dma_req), .dma_addr(dma_addr),
    .dma_ack(dma_ack), .dma_rdata(dma_rdata), .ir_waveform_output(ir_waveform_output), .irq(irq));
  irt_far_model irt_far_model_i (.ref_clk(ref_clk), .resetn(resetn), .lat(lat), .dma_req(dma_req),
    .dma_addr(dma_addr), .dma_ack(dma_ack), .dma_rdata(dma_rdata),
    .ir_waveform_output(ir_waveform_output), .output_invert(inv), .led_on(led_on));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: saw %h, expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input irt_addr_t a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input irt_addr_t a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic print_verdict;
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Measures LED pulse widths and rise times; the hang limit comes last so nothing follows the end.
  always @(posedge ref_clk) begin
    cyc++;
    if (!watch) hi_len = 0;
    else if (led_on) begin
      if (hi_len == 0) rises.push_back(cyc);
      hi_len++;
    end else if (hi_len != 0) begin
      chk(hi_len, (p - r) << e, "carrier high time");
      hi_len = 0;
    end
    if (cyc > 40000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // Configure, enable, start, wait for idle, then decode the bits from pulse times.
  task automatic frame(input int fe, fr, fp, fb, len, input logic fi, input logic [31:0] w0, w1);
    int cnt [0:63];
    int idx, k, bitlen;
    e = fe;
    r = fr;
    p = fp;
    b = fb;
    inv = fi;
    rises.delete();
    irt_far_model_i.mem[64] = w0;
    irt_far_model_i.mem[65] = w1;
    wr(`IRT_OFS_PRESC, fe);
    wr(`IRT_OFS_RISE, fr);
    wr(`IRT_OFS_PERIOD, fp);
    wr(`IRT_OFS_BITPER, fb);
    wr(`IRT_OFS_ADDR, 32'h00000100);
    wr(`IRT_OFS_LEN, len);
    wr(`IRT_OFS_CTRL, {30'h0, fi, 1'b1});
    // The pin register takes the new polarity one edge after the write lands.
    @(posedge ref_clk);
    #1 chk(ir_waveform_output, fi, "idle level");
    watch = 1'b1;
    wr(`IRT_OFS_CTRL, {29'h1, fi, 1'b1});
    rd(`IRT_OFS_STATUS, rv);
    chk(rv, 32'h1, "busy in frame");
    k = 0;
    while (rv[0] === 1'b1 && k < 20000) begin
      rd(`IRT_OFS_STATUS, rv);
      k++;
    end
    chk(rv, 32'h0, "busy after frame");
    chk(ir_waveform_output, fi, "level after frame");
    watch = 1'b0;
    bitlen = (fb * fp) << fe;
    foreach (cnt[i]) cnt[i] = 0;
    foreach (rises[i]) begin
      idx = (rises[i] - rises[0]) / bitlen;
      chk((rises[i] - rises[0]) % (fp << fe), 0, "carrier phase");
      if (idx < 64) cnt[idx]++;
    end
    for (int i = 0; i < 64; i++) begin
      k = (i < 32) ? w0[31 - i] : w1[63 - i];
      chk(cnt[i], (i < len && k == 1) ? fb : 0, "pulses in bit");
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(`IRT_OFS_STATUS, rv);
    chk(rv, 32'h0, "busy at reset");
    rd(`IRT_OFS_IRQ_STAT, rv);
    chk(rv, 32'h0, "status at reset");
    rd(8'h40, rv);
    chk(rv, 32'h0, "unmapped read");
    wr(`IRT_OFS_IRQ_EN, 32'h1);
    frame(1, 2, 4, 2, 35, 1'b0, 32'hA5C30F81, 32'hE0000001);
    rd(`IRT_OFS_IRQ_STAT, rv);
    chk(rv, 32'h1, "done status");
    chk(irq, 1'b1, "irq enabled");
    wr(`IRT_OFS_IRQ_EN, 32'h0);
    @(posedge ref_clk);
    #1 chk(irq, 1'b0, "irq masked");
    wr(`IRT_OFS_IRQ_CLR, 32'h1);
    rd(`IRT_OFS_IRQ_STAT, rv);
    chk(rv, 32'h0, "status cleared");
    wr(`IRT_OFS_IRQ_EN, 32'h1);
    @(posedge ref_clk);
    #1 chk(irq, 1'b0, "irq after clear");
    lat <= 4'h5;
    frame(0, 1, 3, 1, 1, 1'b1, 32'h80000000, 32'h00000000);
    @(posedge ref_clk);
    #1 chk(irq, 1'b1, "irq second frame");
    wr(`IRT_OFS_IRQ_CLR, 32'h1);
    @(posedge ref_clk);
    #1 chk(irq, 1'b0, "irq cleared");
    inv = 1'b0;
    wr(`IRT_OFS_LEN, 32'h0);
    wr(`IRT_OFS_CTRL, 32'h5);
    rd(`IRT_OFS_STATUS, rv);
    chk(rv, 32'h0, "zero length refused");
    wr(`IRT_OFS_LEN, 32'd35);
    wr(`IRT_OFS_CTRL, 32'h5);
    rd(`IRT_OFS_STATUS, rv);
    chk(rv, 32'h1, "busy right after start");
    repeat (20) @(posedge ref_clk);
    wr(`IRT_OFS_CTRL, 32'h0);
    rd(`IRT_OFS_STATUS, rv);
    chk(rv, 32'h0, "busy after disable");
    chk(ir_waveform_output, 1'b0, "level after abort");
    rd(`IRT_OFS_IRQ_STAT, rv);
    chk(rv, 32'h0, "no done on abort");
    chk(irq, 1'b0, "no irq on abort");
    print_verdict();
  end
endmodule
`default_nettype wire
